// >>> dmawe_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; writer and reader may act in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module dmawe_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    // The pointers are one bit wide, so only two entries can be served.
    if (DEPTH != 2) begin : gBadDepth
        $error("dmawe_buffer serves exactly two entries");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData = store[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer and count upkeep.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wrPtr <= ~wrPtr;
            if (pop) rdPtr <= ~rdPtr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage needs no reset; outValid guards every read of it.
    always_ff @(posedge clock) begin
        if (push) store[wrPtr] <= inData;
    end

endmodule

`default_nettype wire

// >>> dmawe_defines.svh
// Constants of the width adapter, error and event logic of the DMA engine.
// Assumes a 32-bit AHB system bus and at most eight channels.
`ifndef DMAWE_DEFINES_SVH
`define DMAWE_DEFINES_SVH

// Register block placement on the system bus.
`define DMAWE_BASE_ADDR 32'hA000_0000
`define DMAWE_BASE_MASK 32'hFFFF_F000
`define DMAWE_STATUS_OFF 12'h000
`define DMAWE_CLEAR_OFF 12'h004
`define DMAWE_STATUS_RST 32'h0000_0000

// Flag positions inside each channel's group of four status bits.
`define DMAWE_ANY_BIT 0
`define DMAWE_DONE_BIT 1
`define DMAWE_HALF_BIT 2
`define DMAWE_ERR_BIT 3
`define DMAWE_FLAGS_PER_CH 4

// Address region that the master treats as reserved.
`define DMAWE_RSV_MASK 32'hF000_0000
`define DMAWE_RSV_BASE 32'hF000_0000

// AHB transfer type and size codes.
`define DMAWE_HTRANS_IDLE 2'h0
`define DMAWE_HTRANS_NONSEQ 2'h2
`define DMAWE_HSIZE_WORD 3'h2

`endif

// >>> dmawe_pkg.sv
// Types shared by the DMA width, error and event logic.
// Assumes item sizes coded as in the AHB size field.
package dmawe_pkg;

    // Item size, coded as the low bits of the AHB size field.
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } dmawe_size_t;

    // One item read from the source, with its transfer attributes.
    typedef struct packed {
        logic [2:0] chan;
        logic [31:0] srcAddr;
        logic [31:0] dstAddr;
        logic [31:0] data;
        dmawe_size_t periphItemSize;
        dmawe_size_t memItemSize;
    } dmawe_item_t;

    // One adapted write waiting for the master port.
    typedef struct packed {
        logic [2:0] chan;
        logic [31:0] addr;
        dmawe_size_t size;
        logic [31:0] data;
    } dmawe_write_t;

    // Master port sequencer states.
    typedef enum logic [2:0] {
        M_IDLE = 3'h1,
        M_ADDR = 3'h2,
        M_DATA = 3'h4
    } dmawe_mstate_t;

endpackage

// >>> dmawe_slave_model.sv
// AHB slave memory behind the engine's master write port.
// Assumes single writes on the engine's clock; size is ignored on store.
`timescale 1ns/1ps
`default_nettype none

module dmawe_slave_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Master port of the engine.
    input wire logic [31:0] haddrM,
    input wire logic [1:0] htransM,
    input wire logic [2:0] hsizeM,
    input wire logic [31:0] hwdataM,
    output logic hreadyM,
    output logic hrespM,
    // Wait states and error reply set by the bench.
    input wire logic [3:0] stall,
    input wire logic failNext
);
    logic pend;
    logic [3:0] waitCnt;
    logic [31:0] pAddr, wordAddr, lastData;
    logic [2:0] lastSize;
    int writes;

//////////////////////////////////////////////////////////////////////////////
    // Ready stays low for the asked wait states, so slow replies are real.
    assign hreadyM = !pend || waitCnt == stall;
    assign hrespM = pend && hreadyM && failNext;

    // The whole word lands at the aligned address, whatever the size.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pend <= 1'b0;
            waitCnt <= 4'h0;
            writes <= 0;
        end else begin
            waitCnt <= (pend && !hreadyM) ? waitCnt + 4'h1 : 4'h0;
            pend <= (htransM == 2'h2 && hreadyM) || (pend && !hreadyM);
            if (pend && hreadyM) begin
                wordAddr <= {pAddr[31:2], 2'h0};
                lastData <= hwdataM;
                writes <= writes + 1;
            end
            if (htransM == 2'h2 && hreadyM) begin
                pAddr <= haddrM;
                lastSize <= hsizeM;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dmawe_top.sv
// Width adapter, master write port, error and event flags of the DMA.
// Assumes requests, events and items come from logic on the same clock.
`include "dmawe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dmawe_top #(
    parameter int NCH = 8
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Register slave on the system bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Master write port.
    output logic [31:0] haddrM,
    output logic [1:0] htransM,
    output logic hwriteM,
    output logic [2:0] hsizeM,
    output logic [31:0] hwdataM,
    input wire logic hreadyM,
    input wire logic hrespM,
    // Item stream from the read side.
    input wire logic itemValid,
    output logic itemReady,
    input wire dmawe_pkg::dmawe_item_t item,
    output logic [31:0] nextSrcAddr,
    output logic [31:0] nextDstAddr,
    // Channel events and enables.
    input wire logic [NCH-1:0] readErr,
    input wire logic [NCH-1:0] halfEvt,
    input wire logic [NCH-1:0] doneEvt,
    input wire logic [NCH-1:0] half_irq_enable,
    input wire logic [NCH-1:0] complete_irq_enable,
    input wire logic [NCH-1:0] error_irq_enable,
    output logic [NCH-1:0] chanDisable,
    output logic irq,
    // Request multiplexing.
    input wire logic [NCH-1:0] periphReq,
    input wire logic adcReq,
    input wire logic [NCH-1:0] reqSelectAdc,
    output logic [NCH-1:0] chanReq
);

    // The status register holds four flags per channel in 32 bits.
    if (NCH < 1 || NCH > 8) begin : gBadNch
        $error("dmawe_top serves one to eight channels");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Reserved-region check, used for both source and destination.
    function automatic logic isReserved(input logic [31:0] a);
        isReserved = ((a & `DMAWE_RSV_MASK) == `DMAWE_RSV_BASE);
    endfunction

    // Address step for one item of the given size.
    function automatic logic [31:0] step(input dmawe_pkg::dmawe_size_t s);
        step = 32'h1 << s;
    endfunction

    // Extend by source size, cut by destination size, repeat a byte or halfword destination over every lane.
    function automatic logic [31:0] adapt(input logic [31:0] d,
            input dmawe_pkg::dmawe_size_t src,
            input dmawe_pkg::dmawe_size_t dst);
        logic [31:0] ext;
        ext = d;
        if (src == dmawe_pkg::SZ_BYTE) ext = {24'h00_0000, d[7:0]};
        if (src == dmawe_pkg::SZ_HALF) ext = {16'h0000, d[15:0]};
        adapt = ext;
        if (dst == dmawe_pkg::SZ_BYTE) adapt = {4{ext[7:0]}};
        if (dst == dmawe_pkg::SZ_HALF) adapt = {2{ext[15:0]}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Request multiplexing.

    // Each channel listens to the converter or to its own peripheral.
    assign chanReq = (reqSelectAdc & {NCH{adcReq}}) |
                     (~reqSelectAdc & periphReq);

    ////////////////////////////////////////////////////////////////////////
    // Item intake and width adaptation.

    logic rsvHit;
    logic take;
    logic bufInValid;
    logic bufInReady;
    dmawe_pkg::dmawe_write_t bufIn;
    dmawe_pkg::dmawe_write_t bufOut;
    logic bufOutValid;
    logic bufOutReady;

    // A reserved address never reaches the bus; it becomes an error.
    assign rsvHit = isReserved(item.srcAddr) || isReserved(item.dstAddr);
    assign itemReady = bufInReady;
    assign take = itemValid && bufInReady;
    assign bufInValid = itemValid && !rsvHit;
    assign bufIn.chan = item.chan;
    assign bufIn.addr = item.dstAddr;
    assign bufIn.size = item.memItemSize;
    assign bufIn.data = adapt(item.data, item.periphItemSize,
                              item.memItemSize);

    // Following addresses step by each side's own item size.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            nextSrcAddr <= 32'h0000_0000;
            nextDstAddr <= 32'h0000_0000;
        end else if (take) begin
            nextSrcAddr <= item.srcAddr + step(item.periphItemSize);
            nextDstAddr <= item.dstAddr + step(item.memItemSize);
        end
    end

    // Two entries let the read side run on while the bus stalls a write.
    dmawe_buffer #(
        .WIDTH($bits(dmawe_pkg::dmawe_write_t)),
        .DEPTH(2)
    ) uBuffer (
        .clock(clock),
        .rstn(rstn),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inData(bufIn),
        .outValid(bufOutValid),
        .outReady(bufOutReady),
        .outData(bufOut)
    );

    ////////////////////////////////////////////////////////////////////////
    // Master write port.

    dmawe_pkg::dmawe_mstate_t mState;
    logic [31:0] pendData;
    logic [2:0] pendChan;
    logic wrErr;

    assign bufOutReady = (mState == dmawe_pkg::M_IDLE);
    assign hwriteM = 1'b1;
    assign wrErr = (mState == dmawe_pkg::M_DATA) && hreadyM && hrespM;

    // One single write at a time: address phase, then data phase.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mState <= dmawe_pkg::M_IDLE;
            htransM <= `DMAWE_HTRANS_IDLE;
            haddrM <= 32'h0000_0000;
            hsizeM <= 3'h0;
            hwdataM <= 32'h0000_0000;
            pendData <= 32'h0000_0000;
            pendChan <= 3'h0;
        end else begin
            unique case (mState)
                dmawe_pkg::M_IDLE: begin
                    if (bufOutValid) begin
                        htransM <= `DMAWE_HTRANS_NONSEQ;
                        haddrM <= bufOut.addr;
                        hsizeM <= {1'b0, bufOut.size};
                        pendData <= bufOut.data;
                        pendChan <= bufOut.chan;
                        mState <= dmawe_pkg::M_ADDR;
                    end
                end
                dmawe_pkg::M_ADDR: begin
                    if (hreadyM) begin
                        htransM <= `DMAWE_HTRANS_IDLE;
                        hwdataM <= pendData;
                        mState <= dmawe_pkg::M_DATA;
                    end
                end
                dmawe_pkg::M_DATA: begin
                    if (hreadyM) mState <= dmawe_pkg::M_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register slave.

    logic selOk;
    logic regWr;
    logic [11:0] regOff;
    logic [31:0] status;
    logic [31:0] clrMask;

    // Only full-word accesses inside the block's window are honoured.
    assign selOk = hsel && hready && htrans[1] &&
        ((haddr & `DMAWE_BASE_MASK) == `DMAWE_BASE_ADDR) &&
        (hsize == `DMAWE_HSIZE_WORD);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture and read data; writes land next cycle.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            regWr <= 1'b0;
            regOff <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            regWr <= selOk && hwrite;
            regOff <= haddr[11:0];
            hrdata <= 32'h0000_0000;
            if (selOk && !hwrite &&
                haddr[11:0] == `DMAWE_STATUS_OFF) hrdata <= status;
        end
    end

    // Writing ones clears flags; the status register ignores writes.
    assign clrMask = (regWr && regOff == `DMAWE_CLEAR_OFF) ?
        hwdata : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Event flags, channel disable and interrupt.

    logic [NCH-1:0] errEvt;
    logic [NCH-1:0] irqTerm;

    // Errors come from the read side, reserved items and the write port.
    always_comb begin
        errEvt = readErr;
        if (take && rsvHit) errEvt[item.chan] = 1'b1;
        if (wrErr) errEvt[pendChan] = 1'b1;
    end

    // The channel's enable is dropped in the cycle after the error.
    always_ff @(posedge clock) begin
        if (!rstn) chanDisable <= '0;
        else chanDisable <= errEvt;
    end

    // Per channel: a hardware set beats a simultaneous software clear.
    for (genvar c = 0; c < 8; c++) begin : gFlags
        localparam int B = c * `DMAWE_FLAGS_PER_CH;
        if (c < NCH) begin : gLive
            logic [3:0] setv;
            assign setv[`DMAWE_DONE_BIT] = doneEvt[c];
            assign setv[`DMAWE_HALF_BIT] = halfEvt[c];
            assign setv[`DMAWE_ERR_BIT] = errEvt[c];
            assign setv[`DMAWE_ANY_BIT] = doneEvt[c] || halfEvt[c] ||
                errEvt[c];
            always_ff @(posedge clock) begin
                if (!rstn) status[B+3:B] <= 4'(`DMAWE_STATUS_RST >> B);
                else status[B+3:B] <= (status[B+3:B] & ~clrMask[B+3:B]) |
                    setv;
            end
            assign irqTerm[c] =
                (status[B+`DMAWE_DONE_BIT] && complete_irq_enable[c]) ||
                (status[B+`DMAWE_HALF_BIT] && half_irq_enable[c]) ||
                (status[B+`DMAWE_ERR_BIT] && error_irq_enable[c]);
        end else begin : gUnused
            assign status[B+3:B] = 4'h0;
        end
    end

    // Enables gate only the output, never the flags themselves.
    assign irq = |irqTerm;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_ERR_FLAGS: assert property (errEvt[0] |=>
        status[`DMAWE_ERR_BIT] && status[`DMAWE_ANY_BIT])
        else $error("error event did not set channel 0 flags");
    AST_SET_WINS: assert property (
        doneEvt[0] && clrMask[1] |=> status[1])
        else $error("clear beat a simultaneous complete event");
    AST_CLEAR: assert property (
        clrMask[2] && !halfEvt[0] |=> !status[2])
        else $error("half flag survived a clear");
    AST_IRQ_GATE: assert property (
        status[3] && !error_irq_enable[0] && irqTerm[NCH-1:1] == '0 &&
        !(status[1] && complete_irq_enable[0]) &&
        !(status[2] && half_irq_enable[0]) |-> !irq)
        else $error("interrupt raised by a disabled flag");
    AST_IRQ_ON: assert property (
        status[11] && error_irq_enable[2] |-> irq)
        else $error("enabled error flag gave no interrupt");
    AST_DISABLE: assert property (errEvt[1] |=> chanDisable[1])
        else $error("channel not disabled after error");
    AST_RSV: assert property (
        take && rsvHit && item.chan == 3'h2 |-> !bufInValid ##1 status[11])
        else $error("reserved access not reported as error");
    AST_REPL: assert property (
        mState == dmawe_pkg::M_DATA && hsizeM == 3'h0 |->
        hwdataM == {4{hwdataM[7:0]}})
        else $error("byte write not replicated on all lanes");
    AST_ADAPT: assert property (
        take && !rsvHit && item.periphItemSize == dmawe_pkg::SZ_WORD &&
        item.memItemSize == dmawe_pkg::SZ_BYTE |=>
        nextSrcAddr == $past(item.srcAddr) + 32'h4 &&
        nextDstAddr == $past(item.dstAddr) + 32'h1)
        else $error("word to byte address steps wrong");
    AST_REQ: assert property (
        reqSelectAdc[0] |-> chanReq[0] == adcReq)
        else $error("converter request not routed to channel 0");
    AST_CLR_READ: assert property (
        selOk && !hwrite && haddr[11:0] == `DMAWE_CLEAR_OFF |=>
        hrdata == 32'h0000_0000)
        else $error("clear register read was not zero");

    COV_WRITE: cover property (mState == dmawe_pkg::M_DATA && hreadyM);
    COV_BUS_ERR: cover property (wrErr);
    COV_FULL: cover property (!bufInReady && itemValid);
    COV_CLEAR: cover property (clrMask != 32'h0000_0000);

endmodule

`default_nettype wire

// >>> dmawe_top_test.sv
// Self-checking bench for the width, error and event logic of the DMA.
// Assumes the slave model and the design files are compiled first.
`include "dmawe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dmawe_top_test;
    `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
        error_cnt++; $display("FAIL %s exp %h got %h", n, e, s); end end
    localparam logic [31:0] STAT = `DMAWE_BASE_ADDR;
    localparam logic [31:0] CLR = `DMAWE_BASE_ADDR | 32'h4;
    logic clock, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready = 1'b1;
    logic hreadyout, hresp, hwriteM, hreadyM, hrespM, itemReady, irq;
    logic itemValid = 1'b0, adcReq = 1'b0, failNext = 1'b0;
    logic [1:0] htrans = 2'h0, htransM;
    logic [2:0] hsize = 3'h2, hsizeM;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [31:0] hrdata, haddrM, hwdataM, nextSrcAddr, nextDstAddr;
    logic [3:0] stall = 4'h0;
    logic [7:0] readErr = 8'h0, halfEvt = 8'h0, doneEvt = 8'h0;
    logic [7:0] half_irq_enable = 8'h0, complete_irq_enable = 8'h0;
    logic [7:0] error_irq_enable = 8'h0, periphReq = 8'h0;
    logic [7:0] reqSelectAdc = 8'h0, chanDisable, chanReq, seen;
    dmawe_pkg::dmawe_item_t item = '0;
    int error_cnt = 0, num_checks = 0, cycles = 0;

    dmawe_top dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .haddrM, .htransM,
        .hwriteM, .hsizeM, .hwdataM, .hreadyM, .hrespM, .itemValid,
        .itemReady, .item, .nextSrcAddr, .nextDstAddr, .readErr, .halfEvt,
        .doneEvt, .half_irq_enable, .complete_irq_enable, .error_irq_enable,
        .chanDisable, .irq, .periphReq, .adcReq, .reqSelectAdc, .chanReq);
    dmawe_slave_model slave (.clock, .rstn, .haddrM, .htransM, .hsizeM,
        .hwdataM, .hreadyM, .hrespM, .stall, .failNext);

//////////////////////////////////////////////////////////////////////////////
    // Free-running clock and a cycle ceiling that cuts a hang short.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One pipelined register access; evt pulses completions in its data phase.
    task automatic bus(input logic w, input logic [31:0] a, d,
                       input logic [2:0] sz, input logic [7:0] evt);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= sz;
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        doneEvt <= evt;
        #1;
        rd = hrdata;
        @(posedge clock);
        doneEvt <= 8'h00;
    endtask
    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, 3'h2, 8'h00);
    endtask
    task automatic rdChk(input string n, input logic [31:0] a, e);
        bus(1'b0, a, 32'h0, 3'h2, 8'h00);
        `CHK(n, e, rd)
    endtask

    // Offers one item and holds it until it is taken; flags any refusal.
    task automatic push(input dmawe_pkg::dmawe_item_t it, output bit refused);
        int n;
        bit ok;
        n = 0;
        refused = 0;
        item <= it;
        itemValid <= 1'b1;
        do begin
            #1;
            ok = itemReady === 1'b1;
            refused |= !ok;
            @(posedge clock);
            n++;
        end while (!ok && n < 40);
    endtask

    // Waits, bounded, until the slave has seen w data phases.
    task automatic waitWr(input int w);
        int n;
        n = 0;
        while (slave.writes != w && n < 200) begin
            @(posedge clock);
            n++;
        end
        `CHK("writes", w, slave.writes)
    endtask

    // Collects channel disable pulses over n cycles.
    task automatic watch(input int n);
        seen = 8'h00;
        repeat (n) begin
            #1;
            seen |= chanDisable;
            @(posedge clock);
        end
    endtask

    // Pulses channel events for one cycle.
    task automatic pulse(input logic [7:0] h, d, e);
        @(posedge clock);
        halfEvt <= h;
        doneEvt <= d;
        readErr <= e;
        @(posedge clock);
        halfEvt <= 8'h00;
        doneEvt <= 8'h00;
        readErr <= 8'h00;
    endtask

    // One item through the adapter: lanes, size, alignment and steps.
    task automatic width(input logic [1:0] ps, ms, input logic [31:0] d, e);
        dmawe_pkg::dmawe_item_t it;
        bit r;
        it = '0;
        it.srcAddr = 32'h2000_0000;
        it.dstAddr = 32'h2000_0103 & ~((32'h1 << ms) - 32'h1);
        it.data = d;
        it.periphItemSize = dmawe_pkg::dmawe_size_t'(ps);
        it.memItemSize = dmawe_pkg::dmawe_size_t'(ms);
        push(it, r);
        itemValid <= 1'b0;
        waitWr(slave.writes + 1);
        `CHK("lanes", e, slave.lastData)
        `CHK("size", {1'b0, ms}, slave.lastSize)
        `CHK("word", 32'h2000_0100, slave.wordAddr)
        `CHK("src", 32'h2000_0000 + (32'h1 << ps), nextSrcAddr)
        `CHK("dst", it.dstAddr + (32'h1 << ms), nextDstAddr)
        $display("width %0d to %0d done", ps, ms);
    endtask

    // Reserved access, slave error and read error on three channels.
    task automatic errors();
        dmawe_pkg::dmawe_item_t it;
        bit r;
        int w;
        it = '0;
        it.chan = 3'h2;
        it.dstAddr = 32'hF000_0010;
        it.periphItemSize = dmawe_pkg::SZ_WORD;
        it.memItemSize = dmawe_pkg::SZ_WORD;
        error_irq_enable <= 8'h04;
        w = slave.writes;
        push(it, r);
        itemValid <= 1'b0;
        watch(8);
        `CHK("dropped", w, slave.writes)
        `CHK("off 2", 8'h04, seen)
        `CHK("irq 2", 1'b1, irq)
        rdChk("err 2", STAT, 32'h0000_0900);
        wr(CLR, 32'h0000_0900);
        #1;
        `CHK("irq clr", 1'b0, irq)
        @(posedge clock);
        it.chan = 3'h5;
        it.dstAddr = 32'h2000_0300;
        failNext <= 1'b1;
        push(it, r);
        itemValid <= 1'b0;
        watch(12);
        failNext <= 1'b0;
        `CHK("tried", w + 1, slave.writes)
        `CHK("off 5", 8'h20, seen)
        `CHK("irq 5", 1'b0, irq)
        error_irq_enable <= 8'h02;
        pulse(8'h00, 8'h00, 8'h02);
        watch(4);
        `CHK("off 1", 8'h02, seen)
        `CHK("irq 1", 1'b1, irq)
        rdChk("err 15", STAT, 32'h0090_0090);
        wr(CLR, 32'hFFFF_FFFF);
        rdChk("err clr", STAT, 32'h0);
        $display("errors done");
    endtask

    // Half events per channel, completions, clears and ignored accesses.
    task automatic events();
        half_irq_enable <= 8'hA5;
        for (int c = 0; c < 8; c++) begin
            pulse(8'h01 << c, 8'h00, 8'h00);
            #1;
            `CHK("half irq", half_irq_enable[c], irq)
            rdChk("half", STAT, 32'h5 << (4 * c));
            wr(CLR, 32'h0);
            rdChk("clr zero", STAT, 32'h5 << (4 * c));
            wr(CLR, 32'h5 << (4 * c));
        end
        pulse(8'h00, 8'hFF, 8'h01);
        #1;
        `CHK("done irq", 1'b0, irq)
        @(posedge clock);
        complete_irq_enable <= 8'h80;
        #1;
        `CHK("done irq on", 1'b1, irq)
        bus(1'b1, CLR, 32'h3, 3'h2, 8'h01);
        wr(STAT, 32'hFFFF_FFFF);
        bus(1'b1, CLR, 32'hFFFF_FFFF, 3'h0, 8'h00);
        rdChk("kept", STAT, 32'h3333_333B);
        rdChk("window", 32'h9000_0000, 32'h0);
        wr(CLR, 32'hFFFF_FFFF);
        rdChk("all clr", STAT, 32'h0);
        $display("events done");
    endtask

    // Five back-to-back items against a slow slave; the buffer must refuse at least one.
    task automatic fill();
        dmawe_pkg::dmawe_item_t it;
        bit r;
        int refusals, w;
        it = '0;
        it.dstAddr = 32'h2000_0200;
        it.periphItemSize = dmawe_pkg::SZ_WORD;
        it.memItemSize = dmawe_pkg::SZ_WORD;
        stall <= 4'h8;
        w = slave.writes;
        refusals = 0;
        for (int i = 0; i < 5; i++) begin
            it.data = 32'h1000 + i;
            push(it, r);
            refusals += r;
        end
        itemValid <= 1'b0;
        `CHK("refused", 1'b1, refusals > 0)
        waitWr(w + 5);
        `CHK("last", 32'h0000_1004, slave.lastData)
        stall <= 4'h0;
        $display("fill done");
    endtask

    // Main sequence.
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rdChk("reset", STAT, 32'h0);
        rdChk("clr reads", CLR, 32'h0);
        periphReq <= 8'h0F;
        adcReq <= 1'b1;
        reqSelectAdc <= 8'h30;
        @(posedge clock);
        #1;
        `CHK("req adc", 8'h3F, chanReq)
        @(posedge clock);
        adcReq <= 1'b0;
        @(posedge clock);
        #1;
        `CHK("req off", 8'h0F, chanReq)
        `CHK("bus reply", 3'h5, {hreadyout, hresp, hwriteM})
        $display("requests done");
        @(posedge clock);
        width(2'h2, 2'h0, 32'hB3B2_B1B0, 32'hB0B0_B0B0);
        width(2'h2, 2'h1, 32'hB7B6_B5B4, 32'hB5B4_B5B4);
        stall <= 4'h2;
        width(2'h1, 2'h2, 32'h1234_B1B0, 32'h0000_B1B0);
        width(2'h0, 2'h1, 32'h5A5A_A5AB, 32'h00AB_00AB);
        width(2'h0, 2'h0, 32'h0000_00AB, 32'hABAB_ABAB);
        stall <= 4'h0;
        width(2'h2, 2'h2, 32'hBFBE_BDBC, 32'hBFBE_BDBC);
        events();
        errors();
        fill();
        tally_and_finish();
    end
endmodule
`default_nettype wire
